//--- pkg/irq_latch_pkg.sv
// shared constants and carrier types for the request latch
// assumes a byte-wide register port with printed byte offsets
package irq_latch_pkg;
   localparam int unsigned ADDR_W = 24;
   localparam logic [23:0] LAST_SRC_ADDR = 24'hFFE023;
   localparam logic [23:0] PEND0_ADDR    = 24'hFFE030;
   localparam logic [23:0] SET0_ADDR     = 24'hFFE031;
   localparam logic [23:0] PEND1_ADDR    = 24'hFFE034;
   localparam logic [23:0] SET1_ADDR     = 24'hFFE035;
   // last-serviced-source field layout and reset
   localparam int unsigned IDX_LSB   = 2;
   localparam int unsigned IDX_W     = 5;
   localparam logic [4:0]  IDX_RESET = 5'h01;
   localparam logic [7:0]  PEND_RESET = 8'h00;
   // group-0 bit positions
   localparam int unsigned BIT_TIMER2 = 7;
   localparam int unsigned BIT_TIMER1 = 6;
   localparam int unsigned BIT_TIMER0 = 5;
   localparam int unsigned BIT_SER0_RX = 4;
   localparam int unsigned BIT_SER0_TX = 3;
   localparam int unsigned BIT_TWOWIRE = 2;
   localparam int unsigned BIT_SPI     = 1;
   localparam int unsigned BIT_CONV    = 0;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef struct packed {
      logic       timer2_request;
      logic       timer1_request;
      logic       timer0_request;
      logic       serial0_receive_request;
      logic       serial0_transmit_request;
      logic       twowire_request;
      logic       serial_peripheral_request;
      logic       converter_request;
   } group0_src_t;

   typedef struct packed {
      logic [7:0] pend0;
      logic [7:0] pend1;
      logic [7:0] pin_prev;
      logic       pin_valid;
      logic [4:0] idx;
      logic [7:0] rdata;
      logic       irq_req;
   } latch_state_t;
endpackage

//--- rtl/irq_request_latch_lastsrc.sv
// request latch with two pending groups and last-serviced-source capture
// assumes sources pulse one cycle, core acks with a vector index
// How it works
// - on core acknowledge, store the five-bit vector index as serviced index
// - last source register: bit 7 and bits 1:0 zero, index 6:2, resets 0x04
// - software may read the last-serviced-source register at any time
// - a source pulse sets its group-0 bit, which holds until cleared
// - with global enable set, any pending bit raises the core request
// - with global enable clear, requests still latch and remain readable
// - writing 1 clears a pending bit, writing 0 leaves it
// - write-only group-0 set register: 1 bits set pending bits
// - group-0 bits 7..0: timer 2,1,0, serial rx, tx, twowire, spi, conv
// - pending bits read 1 while awaiting service, reset to 0
// - group-1 bit x follows the selected pin x of port a or d
// - write-only group-1 set register: 1 bits set group-1 pending bits
// - group-1 bits 7 and 0 may take comparator and debugger requests
// - every level change of a selected pin sets its group-1 bit; here pins 7 and 0 are ignored while the comparator or debugger takes the bit
// - group-1 setting ignores enables; enables only gate forwarding
// - core acknowledge clears the acknowledged pending bit
// - forwarding is gated by the single global interrupt enable
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module irq_request_latch_lastsrc
   import irq_latch_pkg::*;
#(
   parameter int unsigned GROUP_W = 8
) (
   // clock, enable, reset
   input  wire logic        core_clk_in,
   input  wire logic        clk_en_in,
   input  wire logic        sys_rst_in,
   // register port
   input  wire reg_req_t    reg_req_in,
   output logic [7:0]       reg_rdata_out,
   // request sources
   input  wire group0_src_t group0_src_in,
   input  wire logic [7:0]  port_pin_in,
   input  wire logic        pin7_use_comparator_in,
   input  wire logic        comparator_request_in,
   input  wire logic        pin0_use_debugger_in,
   input  wire logic        debugger_request_in,
   // core side
   input  wire logic        global_interrupt_enable_in,
   input  wire logic        ack_in,
   input  wire logic        ack_group_in,
   input  wire logic [2:0]  ack_bit_in,
   input  wire logic [4:0]  ack_index_in,
   output logic             irq_request_out,
   output logic [7:0]       pending_group0_out,
   output logic [7:0]       pending_group1_out
);

   // refuse widths that the fixed byte registers cannot carry
   if (GROUP_W != 8) begin : g_bad_width
      $error("group width must be 8");
   end

   latch_state_t st_r;
   latch_state_t st_nxt;
   logic [7:0]   hw_set0;
   logic [7:0]   hw_set1;
   logic [7:0]   pin_toggle;
   logic [7:0]   sw_set0;
   logic [7:0]   sw_set1;
   logic [7:0]   sw_clr0;
   logic [7:0]   sw_clr1;
   logic [7:0]   ack_clr0;
   logic [7:0]   ack_clr1;

   // group-0 hardware sets in documented bit order
   assign hw_set0 = group0_src_in;

   // pin change detect per bit; first cycle after reset only primes history
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         assign pin_toggle[g] = st_r.pin_valid &&
                                (port_pin_in[g] != st_r.pin_prev[g]);
      end
   endgenerate

   // bits 7 and 0 can be taken over by non-pin sources
   always_comb begin
      hw_set1 = pin_toggle;
      if (pin7_use_comparator_in) begin
         hw_set1[7] = comparator_request_in;
      end
      if (pin0_use_debugger_in) begin
         hw_set1[0] = debugger_request_in;
      end
   end

   // register writes decoded to set and clear masks
   always_comb begin
      sw_set0 = 8'h00;
      sw_set1 = 8'h00;
      sw_clr0 = 8'h00;
      sw_clr1 = 8'h00;
      if (reg_req_in.wr) begin
         unique case (reg_req_in.addr)
            PEND0_ADDR: sw_clr0 = reg_req_in.wdata;
            SET0_ADDR:  sw_set0 = reg_req_in.wdata;
            PEND1_ADDR: sw_clr1 = reg_req_in.wdata;
            SET1_ADDR:  sw_set1 = reg_req_in.wdata;
            default: ;
         endcase
      end
   end

   // acknowledge clears the one bit the core took
   always_comb begin
      ack_clr0 = 8'h00;
      ack_clr1 = 8'h00;
      if (ack_in && !ack_group_in) begin
         ack_clr0[ack_bit_in] = 1'b1;
      end
      if (ack_in && ack_group_in) begin
         ack_clr1[ack_bit_in] = 1'b1;
      end
   end

   // next state; sets are or-ed last so they win over clears
   always_comb begin
      st_nxt = st_r;
      st_nxt.pend0 = (st_r.pend0 & ~(sw_clr0 | ack_clr0)) | hw_set0 | sw_set0;
      st_nxt.pend1 = (st_r.pend1 & ~(sw_clr1 | ack_clr1)) | hw_set1 | sw_set1;
      st_nxt.pin_prev  = port_pin_in;
      st_nxt.pin_valid = 1'b1;
      if (ack_in) begin
         st_nxt.idx = ack_index_in;
      end
      // read data valid the cycle after the strobe only
      st_nxt.rdata = 8'h00;
      if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            LAST_SRC_ADDR: st_nxt.rdata = {1'b0, st_r.idx, 2'b00};
            PEND0_ADDR:    st_nxt.rdata = st_r.pend0;
            PEND1_ADDR:    st_nxt.rdata = st_r.pend1;
            default:       st_nxt.rdata = 8'h00;  // set regs write-only
         endcase
      end
      // registered request; rises on the same edge as the pending bit
      st_nxt.irq_req = global_interrupt_enable_in &&
                       ((st_nxt.pend0 | st_nxt.pend1) != 8'h00);
   end

   // single state register, frozen while clock enable is low
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         st_r.pend0     <= PEND_RESET;
         st_r.pend1     <= PEND_RESET;
         st_r.pin_prev  <= 8'h00;
         st_r.pin_valid <= 1'b0;
         st_r.idx       <= IDX_RESET;
         st_r.rdata     <= 8'h00;
         st_r.irq_req   <= 1'b0;
      end else if (clk_en_in) begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_out      = st_r.rdata;
   assign irq_request_out    = st_r.irq_req;
   assign pending_group0_out = st_r.pend0;
   assign pending_group1_out = st_r.pend1;

   // checks
   property p_set_holds;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && group0_src_in.timer2_request ##1 1'b1 |->
         st_r.pend0[BIT_TIMER2];
   endproperty
   a_set_holds: assert property (p_set_holds)
      else $error("timer2 pulse not latched");

   property p_set_wins;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && group0_src_in.converter_request && reg_req_in.wr &&
      reg_req_in.addr == PEND0_ADDR |=> st_r.pend0[BIT_CONV];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("set lost to clear");

   property p_clear;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && reg_req_in.wr && reg_req_in.addr == PEND0_ADDR &&
      hw_set0 == 8'h00 && !ack_in |=>
         st_r.pend0 == ($past(st_r.pend0) & ~$past(reg_req_in.wdata));
   endproperty
   a_clear: assert property (p_clear)
      else $error("write one clear wrong");

   property p_swset1;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && reg_req_in.wr && reg_req_in.addr == SET1_ADDR |=>
         (st_r.pend1 & $past(reg_req_in.wdata)) == $past(reg_req_in.wdata);
   endproperty
   a_swset1: assert property (p_swset1)
      else $error("group1 set failed");

   property p_forward;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && global_interrupt_enable_in && st_nxt.pend0 != 8'h00
      |=> irq_request_out;
   endproperty
   a_forward: assert property (p_forward)
      else $error("pending request not forwarded");

   property p_gate;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && !global_interrupt_enable_in |=> !irq_request_out;
   endproperty
   a_gate: assert property (p_gate)
      else $error("request forwarded while disabled");

   property p_capture;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && ack_in |=> st_r.idx == $past(ack_index_in);
   endproperty
   a_capture: assert property (p_capture)
      else $error("vector index not captured");

   sequence s_read_last;
      clk_en_in && reg_req_in.rd && reg_req_in.addr == LAST_SRC_ADDR;
   endsequence
   property p_last_fmt;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      s_read_last |=> reg_rdata_out[7] == 1'b0 &&
                      reg_rdata_out[1:0] == 2'b00 &&
                      reg_rdata_out[6:2] == $past(st_r.idx);
   endproperty
   a_last_fmt: assert property (p_last_fmt)
      else $error("last source read format wrong");

   property p_toggle;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && st_r.pin_valid && !pin0_use_debugger_in &&
      port_pin_in[0] != st_r.pin_prev[0] |=> st_r.pend1[0];
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("pin toggle not latched");

   property p_ack_clear;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && ack_in && !ack_group_in &&
      group0_src_in == '0 && !reg_req_in.wr |=>
         !st_r.pend0[$past(ack_bit_in)];
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("acknowledged request not cleared");

   property p_cmp_route;
      @(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && pin7_use_comparator_in && comparator_request_in |=>
         st_r.pend1[7];
   endproperty
   a_cmp_route: assert property (p_cmp_route)
      else $error("comparator request not routed");

endmodule

//--- tb/core_src_model.sv
// stand-in for the processor core and the peripheral request sources
// assumes the bench calls its tasks from one process, one at a time
`timescale 1ns/1ps
module core_src_model
   import irq_latch_pkg::*;
(
   // clock
   input  wire logic   core_clk_in,
   // peripheral request pulses
   output group0_src_t src_out,
   output logic        cmp_out,
   output logic        dbg_out,
   // core side
   output logic        gie_out,
   output logic        ack_out,
   output logic        ack_grp_out,
   output logic [2:0]  ack_bit_out,
   output logic [4:0]  ack_idx_out
);
   // quiet sources, core not taking anything
   initial begin
      src_out = '0;
      cmp_out = 1'b0;
      dbg_out = 1'b0;
      gie_out = 1'b0;
      ack_out = 1'b0;
      ack_grp_out = 1'b0;
      ack_bit_out = 3'h0;
      ack_idx_out = 5'h00;
   end
   // sources pulse for one clock only, never a held level
   task automatic pulse(input group0_src_t m, input logic c, input logic d);
      @(posedge core_clk_in);
      src_out <= m;
      cmp_out <= c;
      dbg_out <= d;
      @(posedge core_clk_in);
      src_out <= '0;
      cmp_out <= 1'b0;
      dbg_out <= 1'b0;
   endtask
   // taking a request drops the global enable in the same step
   task automatic take(input logic g, input logic [2:0] b,
                       input logic [4:0] i);
      @(posedge core_clk_in);
      ack_out <= 1'b1;
      ack_grp_out <= g;
      ack_bit_out <= b;
      ack_idx_out <= i;
      gie_out <= 1'b0;
      @(posedge core_clk_in);
      ack_out <= 1'b0;
      ack_bit_out <= ~b; // stale qualifiers must not be trusted
      ack_idx_out <= ~i;
   endtask
   // global enable is a single flag bit in the core
   task automatic enable(input logic e);
      @(posedge core_clk_in);
      gie_out <= e;
   endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the request latch
// assumes the core stand-in drives pulses, acks and the global enable
`timescale 1ns/1ps
module testbench
   import irq_latch_pkg::*;
;
`define CHK(g, e) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); \
   end \
end
   logic        core_clk_in, sys_rst_in, irq, cmp, dbg, gie, ack, agrp;
   logic        p7sel, p0sel, ce;
   logic [7:0]  rdata, pins, pg0, pg1;
   logic [2:0]  abit;
   logic [4:0]  aidx;
   reg_req_t    req;
   group0_src_t src;
   int          failures, tests_run, cyc;

   irq_request_latch_lastsrc u_dut (.core_clk_in(core_clk_in),
      .clk_en_in(ce), .sys_rst_in(sys_rst_in), .reg_req_in(req),
      .reg_rdata_out(rdata), .group0_src_in(src), .port_pin_in(pins),
      .pin7_use_comparator_in(p7sel), .comparator_request_in(cmp),
      .pin0_use_debugger_in(p0sel), .debugger_request_in(dbg),
      .global_interrupt_enable_in(gie), .ack_in(ack), .ack_group_in(agrp),
      .ack_bit_in(abit), .ack_index_in(aidx), .irq_request_out(irq),
      .pending_group0_out(pg0), .pending_group1_out(pg1));
   core_src_model u_core (.core_clk_in(core_clk_in), .src_out(src),
      .cmp_out(cmp), .dbg_out(dbg), .gie_out(gie), .ack_out(ack),
      .ack_grp_out(agrp), .ack_bit_out(abit), .ack_idx_out(aidx));

   // 40 MHz clock
   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   // hang guard, well above the roughly 115 cycles the run needs
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // one-cycle write strobe, then let the edge land
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk_in);
      req.wr <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [23:0] a, input logic [7:0] e);
      @(posedge core_clk_in);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk_in);
      req.rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask
   // main sequence
   initial begin
      sys_rst_in = 1'b1;
      req = '0;
      pins = 8'h00;
      p7sel = 1'b0;
      p0sel = 1'b0;
      ce = 1'b1;
      failures = 0;
      tests_run = 0;
      cyc = 0;
      repeat (3) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      rd(LAST_SRC_ADDR, 8'h04);
      rd(PEND0_ADDR, 8'h00);
      rd(PEND1_ADDR, 8'h00);
      u_core.enable(1'b1);
      wr(SET0_ADDR, 8'h80);
      `CHK(irq, 1'b1)
      rd(PEND0_ADDR, 8'h80);
      rd(SET0_ADDR, 8'h00);
      wr(PEND0_ADDR, 8'h7F);
      `CHK(pg0, 8'h80)
      wr(PEND0_ADDR, 8'h80);
      `CHK(pg0, 8'h00)
      `CHK(irq, 1'b0)
      // every source lands on its own bit and holds
      for (int i = 0; i < 8; i++) begin
         u_core.pulse(group0_src_t'(8'h01 << i), 1'b0, 1'b0);
         repeat (2) @(posedge core_clk_in);
         #1;
         `CHK(pg0, 8'h01 << i)
         wr(PEND0_ADDR, 8'hFF);
      end
      // polled mode: latched but not forwarded
      u_core.enable(1'b0);
      u_core.pulse(group0_src_t'(8'h04), 1'b0, 1'b0);
      #1;
      `CHK(irq, 1'b0)
      rd(PEND0_ADDR, 8'h04);
      // common entry routine reads back the taken index
      u_core.take(1'b0, 3'h2, 5'h1F);
      #1;
      `CHK(pg0, 8'h00)
      rd(LAST_SRC_ADDR, 8'h7C);
      wr(LAST_SRC_ADDR, 8'h83);
      rd(LAST_SRC_ADDR, 8'h7C);
      // hardware set and software clear in the same cycle
      fork
         u_core.pulse(group0_src_t'(8'h01), 1'b0, 1'b0);
         wr(PEND0_ADDR, 8'h01);
      join
      `CHK(pg0, 8'h01)
      wr(SET1_ADDR, 8'h24);
      `CHK(pg1, 8'h24)
      wr(PEND1_ADDR, 8'hFF);
      // both pin edges set the bits, enable still low
      @(posedge core_clk_in);
      pins <= 8'h09;
      rd(PEND1_ADDR, 8'h09);
      wr(PEND1_ADDR, 8'hFF);
      @(posedge core_clk_in);
      pins <= 8'h00;
      rd(PEND1_ADDR, 8'h09);
      wr(PEND1_ADDR, 8'hFF);
      @(posedge core_clk_in);
      p7sel <= 1'b1;
      p0sel <= 1'b1;
      u_core.pulse('0, 1'b1, 1'b1);
      #1;
      `CHK(pg1, 8'h81)
      u_core.take(1'b1, 3'h7, 5'h05);
      #1;
      `CHK(pg1, 8'h01)
      rd(LAST_SRC_ADDR, 8'h14);
      // mid-run reset brings back the reset values
      @(posedge core_clk_in);
      sys_rst_in <= 1'b1;
      @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      rd(LAST_SRC_ADDR, 8'h04);
      rd(PEND1_ADDR, 8'h00);
      // clock enable low must drop a set write
      @(posedge core_clk_in);
      ce <= 1'b0;
      wr(SET0_ADDR, 8'h02);
      `CHK(pg0, 8'h00)
      @(posedge core_clk_in);
      ce <= 1'b1;
      close_out();
   end
endmodule
